// ### dv/dmp_partner.sv
// Purpose: arbiter and shared ram beside the dma port
// Assumes: memory clock runs free with a 48 ns period
// Notes:   read data is a changing pattern outside read strobes
`timescale 1ns/1ps
module dmp_partner import dmp_pkg::*; (
    // pins
    input wire logic clk,
    input dmp_mem_out_t memOut,
    input wire logic forceGrant,
    output logic mclk,
    output logic mem_grant_n,
    output logic [15:0] ramDataIn,
    output logic [15:0] wrData
);
    initial mclk = 1'h0;
    initial mem_grant_n = 1'h1;
    always #24 mclk = ~mclk;
    // grant a request and keep it until the acknowledge ends
    always @(posedge clk) begin
        mem_grant_n <= memOut.mem_request_n && memOut.mem_ack_n && !forceGrant;
    end
    // ram drives its addressed word only under its read strobe, the memory clock pattern otherwise
    assign ramDataIn = memOut.ram_read_n ? {16{mclk}} :
        memOut.addr ^ 16'h3c00;
    // capture written word as the strobe ends
    always @(posedge memOut.ram_write_n) wrData <= memOut.dataOut;
endmodule

// ### dv/dmp_top_props.sv
// Purpose: pin timing checks on the dma port and channel a
// Assumes: memory clock of 48 ns, so 12 block clocks a period
// Notes:   bound onto every dmp_top instance
`timescale 1ns/1ps
module dmp_top_props import dmp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // watched outputs
    input dmp_mem_out_t memOut,
    input wire logic cmdBusy,
    input wire logic [1:0] txBusy,
    input wire logic tx_chan_a_true,
    input wire logic tx_chan_a_compl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // steps of an access
    sequence ackHeld; !memOut.mem_ack_n [*8]; endsequence
    sequence halfHeld; $stable(memOut.memory_clock_half) [*4]; endsequence
    req_off_a: assert property (
        !memOut.mem_ack_n |-> memOut.mem_request_n)
        else $error("request held during acknowledge");
    pass_idle_a: assert property (
        !memOut.mem_grant_pass_n |-> !$past(cmdBusy))
        else $error("grant passed while busy");
    ack_hold_a: assert property (
        $fell(memOut.mem_ack_n) |-> ackHeld)
        else $error("acknowledge dropped early");
    float_ack_a: assert property (
        memOut.bus_float_ctl_n == memOut.mem_ack_n)
        else $error("float and acknowledge differ");
    float_oe_a: assert property (
        !memOut.bus_float_ctl_n == memOut.addrOe)
        else $error("float without address drive");
    sel_ack_a: assert property (
        memOut.ram_select_out_n == memOut.mem_ack_n)
        else $error("select differs from acknowledge");
    strobe_in_a: assert property (
        !(memOut.ram_read_n && memOut.ram_write_n) |-> !memOut.mem_ack_n)
        else $error("strobe outside access");
    strobe_len_a: assert property (
        $fell(memOut.ram_read_n) |-> !memOut.ram_read_n [*8])
        else $error("read strobe too short");
    half_rate_a: assert property (
        $changed(memOut.memory_clock_half) |=> halfHeld)
        else $error("half clock too fast");
    tx_idle_a: assert property (
        !txBusy[0] |-> !tx_chan_a_true && !tx_chan_a_compl)
        else $error("idle line not low");
    tx_pair_a: assert property (
        txBusy[0] |-> tx_chan_a_true != tx_chan_a_compl)
        else $error("line pair not complementary");
endmodule
bind dmp_top dmp_top_props dmp_top_props_inst (.clk(clk), .arst_n(arst_n),
    .memOut(memOut), .cmdBusy(cmdBusy), .txBusy(txBusy),
    .tx_chan_a_true(tx_chan_a_true), .tx_chan_a_compl(tx_chan_a_compl));

// ### dv/dmp_top_tb.sv
// Purpose: self-checking bench of dmp_top
// Assumes: channel a loops transmit back into receive
// Notes:   one task per scenario
`timescale 1ns/1ps
module dmp_top_tb import dmp_pkg::*;;
    logic clk = 1'h0, arst_n = 1'h0, txValid = 1'h0, forceGrant = 1'h0;
    logic mclk, grantN, txA, txAc, txB, txBc, cmdTaken, cmdBusy, rdValid;
    logic [15:0] ramData, txData = 16'h0000, rdData, wrData;
    logic [1:0] txBusy, rxFault, faultSeen = 2'h0, chanEn = 2'h3;
    dmp_mem_out_t memOut;
    dmp_cmd_t cmdIn = '0;
    int errors = 0, tests_run = 0;
    always #2 clk = ~clk;
    dmp_top dmp_top_inst (.clk(clk), .arst_n(arst_n), .mclk(mclk),
        .mem_grant_n(grantN), .ramDataIn(ramData), .memOut(memOut),
        .rx_chan_a_true(txA), .rx_chan_a_compl(txAc), .rx_chan_b_true(txB),
        .rx_chan_b_compl(txBc), .tx_chan_a_true(txA), .tx_chan_a_compl(txAc),
        .tx_chan_b_true(txB), .tx_chan_b_compl(txBc), .chanEnable(chanEn),
        .rxFault(rxFault), .txValid(txValid), .txChan(1'h0), .txData(txData),
        .txBusy(txBusy), .cmdIn(cmdIn), .cmdTaken(cmdTaken),
        .cmdBusy(cmdBusy), .rdValid(rdValid), .rdData(rdData));
    dmp_partner dmp_partner_inst (.clk(clk), .memOut(memOut),
        .forceGrant(forceGrant), .mclk(mclk), .mem_grant_n(grantN),
        .ramDataIn(ramData), .wrData(wrData));
    // receive faults are one-cycle pulses, so keep them sticky
    always @(negedge clk) faultSeen |= rxFault;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // present a command until taken, then drop its valid
    task automatic issue(input logic w, input logic [15:0] a,
        input logic [2:0] c);
        cmdIn = '{valid: 1'h1, write: w, addr: a, count: c};
        for (int n = 0; n < 9000 && !cmdTaken; n++) @(negedge clk);
        check(16'(cmdTaken), 16'h0001);
        cmdIn.valid = 1'h0;
    endtask
    task automatic waitIdle;
        for (int n = 0; n < 900 && cmdBusy; n++) @(negedge clk);
        check(16'(cmdBusy), 16'h0000);
    endtask
    task automatic test_tx_write;
        txData = 16'ha5c3;
        txValid = 1'h1;
        @(negedge clk);
        txValid = 1'h0;
        repeat (62) @(negedge clk);
        for (int i = 0; i < 32; i++) begin
            check(16'(txA), 16'(txData[15 - i / 2] ^ i[0]));
            check(16'(txAc), 16'(!txData[15 - i / 2] ^ i[0]));
            repeat (125) @(negedge clk);
        end
        check(16'({txA, txAc, txBusy}), 16'h0000);
        issue(1'h1, 16'h0040, 3'h1);
        check(16'(memOut.burst), 16'h0000);
        waitIdle;
        check(wrData, 16'ha5c3);
        check(16'(faultSeen), 16'h0000);
        $display("test tx and write done");
    endtask
    task automatic test_read;
        issue(1'h0, 16'h0100, 3'h3);
        check(16'(memOut.burst), 16'h0001);
        for (int k = 0; k < 3; k++) begin
            for (int n = 0; n < 900 && !rdValid; n++) @(negedge clk);
            check(rdData, (16'h0100 + 16'(k)) ^ 16'h3c00);
            @(negedge clk);
        end
        waitIdle;
        check(16'(memOut.burst), 16'h0000);
        $display("test read done");
    endtask
    task automatic test_disable;
        chanEn = 2'h2;
        txValid = 1'h1;
        @(negedge clk);
        txValid = 1'h0;
        repeat (3) @(negedge clk);
        check(16'({txA, txAc, txBusy}), 16'h0000);
        chanEn = 2'h3;
        $display("test channel disable done");
    endtask
    task automatic test_pass_abort;
        forceGrant = 1'h1;
        repeat (8) @(negedge clk);
        check(16'(memOut[41:40]), 16'h0002);
        forceGrant = 1'h0;
        repeat (8) @(negedge clk);
        issue(1'h0, 16'h0200, 3'h6);
        for (int n = 0; n < 900 && memOut.mem_ack_n; n++) @(negedge clk);
        check(16'(memOut.mem_ack_n), 16'h0000);
        arst_n = 1'h0;
        #1 check(16'(memOut[42:34]), 16'h01fc);
        repeat (5) @(negedge clk);
        arst_n = 1'h1;
        repeat (2) @(negedge clk);
        check(16'(memOut[42:34]), 16'h01fc);
        check(16'(cmdBusy), 16'h0000);
        $display("test pass and abort done");
    endtask
    initial begin
        repeat (5) @(negedge clk);
        arst_n = 1'h1;
        check(16'(memOut[42:34]), 16'h01fc);
        check(16'(regAddr(1)), 16'h0001);
        test_tx_write;
        test_read;
        test_disable;
        test_pass_abort;
        tally_and_finish;
    end
    initial begin
        #100000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule

// ### logic/dmp_fifo.sv
//----------------------------------------------------------------------
// Purpose: word fifo between the biphase receivers and the dma writer
//----------------------------------------------------------------------
// Purpose: flop storage with valid and ready on both sides
// Assumes: depth is a power of two of at least two
// Notes:   level output lets the writer wait for a whole burst
`timescale 1ns/1ps
module dmp_fifo import dmp_pkg::*; #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("dmp_fifo depth must be a power of two, two or more");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [LW-1:0] cnt;
    } dmp_fifo_st_t;

    dmp_fifo_st_t r;
    dmp_fifo_st_t n;
    logic push;
    logic pop;

    // handshake flags straight from the count
    assign inReady = (r.cnt != LW'(DEPTH));
    assign outValid = (r.cnt != '0);
    assign outData = r.mem[r.rd];
    assign level = r.cnt;
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // pointer and count update
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = inData;
            n.wr = AW'(r.wr + 1'h1);
        end
        if (pop) begin
            n.rd = AW'(r.rd + 1'h1);
        end
        case ({push, pop})
            2'h2: n.cnt = LW'(r.cnt + 1'h1);
            2'h1: n.cnt = LW'(r.cnt - 1'h1);
            default: n.cnt = r.cnt;
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule

// ### logic/dmp_pkg.sv
//----------------------------------------------------------------------
// Purpose: shared constants, carriers and helpers of the dma memory port
//----------------------------------------------------------------------
// Purpose: timing counts, pin layout, reset values and packed carriers
// Assumes: one 250 MHz clock; memory clock and pins are asynchronous
// Notes:   every bit timing count here is derived from a time and the clock rate
package dmp_pkg;

    //------------------------------------------------------------------
    // clock and biphase timing
    //------------------------------------------------------------------
    localparam int CLK_MHZ = 250;          // block clock rate
    localparam int MCLK_MIN_MHZ = 6;       // slowest memory clock served
    localparam int MCLK_MAX_MHZ = 12;      // fastest memory clock served
    localparam int BIT_NS = 1000;          // one biphase bit time
    localparam int BIT_CYC = BIT_NS * CLK_MHZ / 1000;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int QUART_CYC = BIT_CYC / 4;
    localparam int CNT_W = $clog2(BIT_CYC + 1);
    localparam int WORD_BITS = 16;
    localparam int BIDX_W = $clog2(WORD_BITS);

    //------------------------------------------------------------------
    // dma transfer limits
    //------------------------------------------------------------------
    localparam int MAX_WORDS = 6;          // most data words in one command
    localparam int BURST_MIN = 2;          // words that make a burst
    localparam int FIFO_DEPTH = 16;

    //------------------------------------------------------------------
    // positions of the synchronised pins
    //------------------------------------------------------------------
    localparam int PIN_MCLK = 0;
    localparam int PIN_GRANT = 1;
    localparam int PIN_RXA_T = 2;          // channel n true at 2 + 2n
    localparam int PIN_RXA_C = 3;          // channel n compl at 3 + 2n
    localparam int PIN_DATA = 6;
    localparam int PIN_W = PIN_DATA + WORD_BITS;
    localparam logic [PIN_W-1:0] PIN_RESET = 22'h000002; // grant idle high

    //------------------------------------------------------------------
    // types
    //------------------------------------------------------------------
    typedef enum logic [1:0] {DS_IDLE, DS_REQ, DS_XFER} dmp_dma_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_GAP} dmp_rx_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [2:0] count;
    } dmp_cmd_t;

    typedef struct packed {
        logic mem_request_n;
        logic mem_ack_n;
        logic mem_grant_pass_n;
        logic bus_float_ctl_n;
        logic ram_select_out_n;
        logic ram_read_n;
        logic ram_write_n;
        logic burst;
        logic memory_clock_half;
        logic addrOe;
        logic dataOe;
        logic [15:0] addr;
        logic [15:0] dataOut;
    } dmp_mem_out_t;

    typedef struct packed {
        dmp_rx_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [BIDX_W-1:0] bitIdx;
        logic [WORD_BITS-1:0] shift;
    } dmp_rx_ch_t;

    typedef struct packed {
        logic active;
        logic half;
        logic [CNT_W-1:0] cnt;
        logic [BIDX_W-1:0] bitIdx;
        logic [WORD_BITS-1:0] shift;
        logic lineTrue;
        logic lineCompl;
    } dmp_tx_ch_t;

    // all memory pins inactive
    localparam dmp_mem_out_t MEM_IDLE = '{
        mem_request_n: 1'h1, mem_ack_n: 1'h1, mem_grant_pass_n: 1'h1,
        bus_float_ctl_n: 1'h1, ram_select_out_n: 1'h1, ram_read_n: 1'h1,
        ram_write_n: 1'h1, burst: 1'h0, memory_clock_half: 1'h0,
        addrOe: 1'h0, dataOe: 1'h0, addr: 16'h0000, dataOut: 16'h0000};

    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    // register select code is the plain binary of its number
    function automatic logic [3:0] regAddr(input int unsigned num);
        return num[3:0];
    endfunction

    // word count of a command, forced into 1..MAX_WORDS
    function automatic logic [2:0] clampCount(input logic [2:0] c);
        if (c == 3'h0) begin
            return 3'h1;
        end
        if (c > 3'(MAX_WORDS)) begin
            return 3'(MAX_WORDS);
        end
        return c;
    endfunction

endpackage

// ### logic/dmp_top.sv
//----------------------------------------------------------------------
// Purpose: dma memory port with two biphase channel pairs
//----------------------------------------------------------------------
// Purpose: request, grant, acknowledge and strobe the shared ram;
//          encode and decode two biphase channels; buffer rx words
// Assumes: memory clock, grant, rx pins and ram data are asynchronous
// Notes:   received words are queued and written to ram by commands
`timescale 1ns/1ps
module dmp_top import dmp_pkg::*; #(
    parameter int FIFO_WORDS = FIFO_DEPTH
) (
    // clock and master reset
    input wire logic clk,
    input wire logic arst_n,
    // memory clock and arbiter
    input wire logic mclk,
    input wire logic mem_grant_n,
    // shared ram
    input wire logic [15:0] ramDataIn,
    output dmp_mem_out_t memOut,
    // biphase receive pairs
    input wire logic rx_chan_a_true,
    input wire logic rx_chan_a_compl,
    input wire logic rx_chan_b_true,
    input wire logic rx_chan_b_compl,
    // biphase transmit pairs
    output logic tx_chan_a_true,
    output logic tx_chan_a_compl,
    output logic tx_chan_b_true,
    output logic tx_chan_b_compl,
    // channel control and status
    input wire logic [1:0] chanEnable,
    output logic [1:0] rxFault,
    // transmit word port
    input wire logic txValid,
    input wire logic txChan,
    input wire logic [15:0] txData,
    output logic [1:0] txBusy,
    // dma command port
    input dmp_cmd_t cmdIn,
    output logic cmdTaken,
    output logic cmdBusy,
    // read data port
    output logic rdValid,
    output logic [15:0] rdData
);
    localparam int LVL_W = $clog2(FIFO_WORDS + 1);

    if (CLK_MHZ < 4 * MCLK_MAX_MHZ || MCLK_MIN_MHZ > MCLK_MAX_MHZ) begin
        : g_chk
        $error("dmp_top clock too slow to sample the memory clock");
    end

    //------------------------------------------------------------------
    // state of the block
    //------------------------------------------------------------------
    typedef struct packed {
        dmp_dma_state_t dma;
        logic wr;
        logic phase;
        logic [2:0] left;
        dmp_mem_out_t mem;
        logic cmdTaken;
        logic cmdBusy;
        logic rdValid;
        logic [15:0] rdData;
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic mclkPrev;
        dmp_rx_ch_t [1:0] rx;
        logic [1:0] hold;
        logic [1:0][15:0] holdData;
        logic [1:0] rxFault;
        dmp_tx_ch_t [1:0] tx;
        logic [1:0] txBusy;
    } dmp_top_st_t;

    // constant taken by every flop under reset
    function automatic dmp_top_st_t resetState();
        dmp_top_st_t s;
        s = '0;
        s.dma = DS_IDLE;
        s.mem = MEM_IDLE;
        s.s1 = PIN_RESET;
        s.s2 = PIN_RESET;
        return s;
    endfunction

    localparam dmp_top_st_t ST_RESET = resetState();

    dmp_top_st_t r;
    dmp_top_st_t n;
    logic mclkRise;
    logic grantSeen;
    logic [2:0] cmdWords;
    logic pushValid;
    logic [15:0] pushData;
    logic fifoInReady;
    logic fifoValid;
    logic fifoPop;
    logic [15:0] fifoData;
    logic [LVL_W-1:0] fifoLevel;

    //------------------------------------------------------------------
    // received word queue
    //------------------------------------------------------------------
    dmp_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .inValid(pushValid),
        .inReady(fifoInReady),
        .inData(pushData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData),
        .level(fifoLevel)
    );

    // channel a holding word goes first
    assign pushValid = r.hold[0] | r.hold[1];
    assign pushData = r.hold[0] ? r.holdData[0] : r.holdData[1];
    assign cmdWords = clampCount(cmdIn.count);

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb begin
        n = r;
        fifoPop = 1'h0;
        // pins pass two flops before use
        n.s1 = {ramDataIn, rx_chan_b_compl, rx_chan_b_true,
                rx_chan_a_compl, rx_chan_a_true, mem_grant_n, mclk};
        n.s2 = r.s1;
        n.mclkPrev = r.s2[PIN_MCLK];
        mclkRise = r.s2[PIN_MCLK] & ~r.mclkPrev;
        // grant counts at the edge that raises the half-rate clock
        grantSeen = mclkRise & ~r.mem.memory_clock_half & ~r.s2[PIN_GRANT];
        n.cmdTaken = 1'h0;
        n.rdValid = 1'h0;
        n.rxFault = 2'h0;

        // half-rate memory clock
        if (mclkRise) begin
            n.mem.memory_clock_half = ~r.mem.memory_clock_half;
        end

        // forward a grant that this port does not want
        n.mem.mem_grant_pass_n = (r.dma == DS_IDLE) ?
            r.s2[PIN_GRANT] : 1'h1;

        // dma handshake and word cycles
        case (r.dma)
            DS_IDLE: begin
                if (cmdIn.valid && (!cmdIn.write ||
                    fifoLevel >= LVL_W'(cmdWords))) begin
                    n.dma = DS_REQ;
                    n.cmdTaken = 1'h1;
                    n.wr = cmdIn.write;
                    n.left = cmdWords;
                    n.mem.addr = cmdIn.addr;
                    n.mem.burst = (cmdWords >= 3'(BURST_MIN));
                    n.mem.mem_request_n = 1'h0;
                end
            end
            DS_REQ: begin
                if (grantSeen) begin
                    n.dma = DS_XFER;
                    n.phase = 1'h0;
                    n.mem.mem_request_n = 1'h1;
                    n.mem.mem_ack_n = 1'h0;
                    n.mem.bus_float_ctl_n = 1'h0;
                    n.mem.ram_select_out_n = 1'h0;
                    n.mem.addrOe = 1'h1;
                    n.mem.dataOe = r.wr;
                    if (r.wr) begin
                        n.mem.dataOut = fifoData;
                        fifoPop = 1'h1;
                        n.mem.ram_write_n = 1'h0;
                    end else begin
                        n.mem.ram_read_n = 1'h0;
                    end
                end
            end
            DS_XFER: begin
                // one word spans two memory clock rises
                if (mclkRise) begin
                    if (!r.phase) begin
                        n.phase = 1'h1;
                        n.mem.ram_read_n = 1'h1;
                        n.mem.ram_write_n = 1'h1;
                        if (!r.wr) begin
                            n.rdValid = 1'h1;
                            n.rdData = r.s2[PIN_DATA +: 16];
                        end
                    end else if (r.left == 3'h1) begin
                        n.dma = DS_IDLE;
                        n.mem.mem_ack_n = 1'h1;
                        n.mem.bus_float_ctl_n = 1'h1;
                        n.mem.ram_select_out_n = 1'h1;
                        n.mem.addrOe = 1'h0;
                        n.mem.dataOe = 1'h0;
                        n.mem.burst = 1'h0;
                    end else begin
                        n.left = 3'(r.left - 1'h1);
                        n.mem.addr = 16'(r.mem.addr + 1'h1);
                        n.phase = 1'h0;
                        if (r.wr) begin
                            n.mem.dataOut = fifoData;
                            fifoPop = 1'h1;
                            n.mem.ram_write_n = 1'h0;
                        end else begin
                            n.mem.ram_read_n = 1'h0;
                        end
                    end
                end
            end
            default: begin
                n.dma = DS_IDLE;
                n.mem = MEM_IDLE;
            end
        endcase
        n.cmdBusy = (n.dma != DS_IDLE);

        // queue takes a held word; a new word beats the clear
        if (pushValid && fifoInReady) begin
            if (r.hold[0]) begin
                n.hold[0] = 1'h0;
            end else begin
                n.hold[1] = 1'h0;
            end
        end

        for (int ch = 0; ch < 2; ch++) begin
            // biphase receiver, sampled mid first half of each bit
            case (r.rx[ch].st)
                RX_IDLE: begin
                    if (chanEnable[ch] && (r.s2[PIN_RXA_T + 2 * ch] ^
                        r.s2[PIN_RXA_C + 2 * ch])) begin
                        n.rx[ch].st = RX_BITS;
                        n.rx[ch].cnt = CNT_W'(QUART_CYC);
                        n.rx[ch].bitIdx = '0;
                    end
                end
                RX_BITS: begin
                    if (r.rx[ch].cnt != '0) begin
                        n.rx[ch].cnt = CNT_W'(r.rx[ch].cnt - 1'h1);
                    end else if (r.s2[PIN_RXA_T + 2 * ch] ==
                        r.s2[PIN_RXA_C + 2 * ch]) begin
                        n.rx[ch].st = RX_GAP;
                        n.rxFault[ch] = 1'h1;
                    end else begin
                        n.rx[ch].shift = {r.rx[ch].shift[14:0],
                            r.s2[PIN_RXA_T + 2 * ch]};
                        if (r.rx[ch].bitIdx == BIDX_W'(WORD_BITS - 1)) begin
                            n.rx[ch].st = RX_GAP;
                            if (n.hold[ch]) begin
                                n.rxFault[ch] = 1'h1;
                            end else begin
                                n.hold[ch] = 1'h1;
                                n.holdData[ch] = n.rx[ch].shift;
                            end
                        end else begin
                            n.rx[ch].bitIdx = BIDX_W'(r.rx[ch].bitIdx + 1'h1);
                            n.rx[ch].cnt = CNT_W'(BIT_CYC - 1);
                        end
                    end
                end
                RX_GAP: begin
                    if (!r.s2[PIN_RXA_T + 2 * ch] &&
                        !r.s2[PIN_RXA_C + 2 * ch]) begin
                        n.rx[ch].st = RX_IDLE;
                    end
                end
                default: n.rx[ch].st = RX_IDLE;
            endcase

            // biphase transmitter, msb first, idle low on both lines
            if (!r.tx[ch].active || !chanEnable[ch]) begin
                n.tx[ch].active = 1'h0;
                n.tx[ch].lineTrue = 1'h0;
                n.tx[ch].lineCompl = 1'h0;
                if (!r.tx[ch].active && txValid && chanEnable[ch] &&
                    int'(txChan) == ch) begin
                    n.tx[ch].active = 1'h1;
                    n.tx[ch].half = 1'h0;
                    n.tx[ch].bitIdx = '0;
                    n.tx[ch].shift = txData;
                    n.tx[ch].cnt = CNT_W'(HALF_CYC - 1);
                    n.tx[ch].lineTrue = txData[15];
                    n.tx[ch].lineCompl = ~txData[15];
                end
            end else if (r.tx[ch].cnt != '0) begin
                n.tx[ch].cnt = CNT_W'(r.tx[ch].cnt - 1'h1);
            end else if (!r.tx[ch].half) begin
                n.tx[ch].half = 1'h1;
                n.tx[ch].lineTrue = r.tx[ch].lineCompl;
                n.tx[ch].lineCompl = r.tx[ch].lineTrue;
                n.tx[ch].cnt = CNT_W'(HALF_CYC - 1);
            end else if (r.tx[ch].bitIdx == BIDX_W'(WORD_BITS - 1)) begin
                n.tx[ch].active = 1'h0;
                n.tx[ch].lineTrue = 1'h0;
                n.tx[ch].lineCompl = 1'h0;
            end else begin
                n.tx[ch].bitIdx = BIDX_W'(r.tx[ch].bitIdx + 1'h1);
                n.tx[ch].shift = {r.tx[ch].shift[14:0], 1'h0};
                n.tx[ch].half = 1'h0;
                n.tx[ch].lineTrue = r.tx[ch].shift[14];
                n.tx[ch].lineCompl = ~r.tx[ch].shift[14];
                n.tx[ch].cnt = CNT_W'(HALF_CYC - 1);
            end
            n.txBusy[ch] = n.tx[ch].active;
        end
    end

    //------------------------------------------------------------------
    // state register
    //------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= ST_RESET;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state flops
    assign memOut = r.mem;
    assign tx_chan_a_true = r.tx[0].lineTrue;
    assign tx_chan_a_compl = r.tx[0].lineCompl;
    assign tx_chan_b_true = r.tx[1].lineTrue;
    assign tx_chan_b_compl = r.tx[1].lineCompl;
    assign txBusy = r.txBusy;
    assign rxFault = r.rxFault;
    assign cmdTaken = r.cmdTaken;
    assign cmdBusy = r.cmdBusy;
    assign rdValid = r.rdValid;
    assign rdData = r.rdData;

endmodule
